// ===== core/hspc_channel.sv
`timescale 1ns/100ps
// One counter channel: count, wrap, preset and two latched compares
module hspc_channel
    import hspc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Settings
    input wire logic [3:0] mode,
    input wire logic [31:0] ring,
    input wire logic [31:0] preset_val,
    input wire logic [31:0] cmp1,
    input wire logic [31:0] cmp2,
    input wire logic init,
    input wire logic clr1,
    input wire logic clr2,
    input wire logic sw_preset,
    // Steps and pins
    input wire logic step_up,
    input wire logic step_dn,
    input wire logic preset_in,
    input wire logic inhibit,
    // State
    output logic [31:0] count,
    output logic first_compare_output,
    output logic second_compare_output
);
    logic [31:0] lim16;
    logic [31:0] next_count;
    logic wide;

    assign wide = ~mode[0];
    // Ring length of 65536 or above still tops out at 65535
    assign lim16 = (ring == ZERO32 || ring > MAX16) ? MAX16 : ring - ONE32;

    // Next count with wrap at either end
    always_comb
    begin
        next_count = count;
        if (step_up)
        begin
            if (wide)
                next_count = (count == MAX32) ? MIN32 : count + ONE32;
            else
                next_count = (count >= lim16) ? ZERO32 : count + ONE32;
        end
        else if (step_dn)
        begin
            if (wide)
                next_count = (count == MIN32) ? MAX32 : count - ONE32;
            else
                next_count = (count == ZERO32 || count > lim16) ? lim16 : count - ONE32;
        end
    end

    // Count register: preset beats counting, inhibit freezes
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            count <= ZERO32;
        else if (init)
            count <= ZERO32;
        else if (preset_in || sw_preset)
            count <= preset_val;
        else if (!inhibit)
            count <= next_count;
    end

    // Compare outputs are set the cycle after a match; set beats reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            first_compare_output <= 1'b0;
            second_compare_output <= 1'b0;
        end
        else
        begin
            if (count == cmp1)
                first_compare_output <= 1'b1;
            else if (clr1 || init)
                first_compare_output <= 1'b0;
            if (count == cmp2)
                second_compare_output <= 1'b1;
            else if (clr2 || init)
                second_compare_output <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_set1;
        @(posedge ref_clk) disable iff (!arst_n)
        count == cmp1 |=> first_compare_output;
    endproperty
    a_set1: assert property (p_set1) else $error("compare 1 not set");
    property p_hold1;
        @(posedge ref_clk) disable iff (!arst_n)
        first_compare_output && !clr1 && !init |=> first_compare_output;
    endproperty
    a_hold1: assert property (p_hold1) else $error("compare 1 dropped");
    property p_clr2;
        @(posedge ref_clk) disable iff (!arst_n)
        clr2 && count != cmp2 |=> !second_compare_output;
    endproperty
    a_clr2: assert property (p_clr2) else $error("compare 2 not cleared");
    property p_inh;
        @(posedge ref_clk) disable iff (!arst_n)
        inhibit && !init && !preset_in && !sw_preset |=> $stable(count);
    endproperty
    a_inh: assert property (p_inh) else $error("count moved");
    property p_pre;
        @(posedge ref_clk) disable iff (!arst_n)
        preset_in && !init |=> count == $past(preset_val);
    endproperty
    a_pre: assert property (p_pre) else $error("preset lost");
    property p_wrap32;
        @(posedge ref_clk) disable iff (!arst_n)
        wide && step_up && count == MAX32 && !inhibit && !init && !preset_in && !sw_preset
        |=> count == MIN32;
    endproperty
    a_wrap32: assert property (p_wrap32) else $error("32-bit wrap wrong");
    property p_lim16;
        @(posedge ref_clk) disable iff (!arst_n)
        !wide && !init && !preset_in && !sw_preset && $past(!wide) && $past(count) <= $past(lim16)
        |-> count <= MAX16;
    endproperty
    a_lim16: assert property (p_lim16) else $error("16-bit range");
    property p_dn16;
        @(posedge ref_clk) disable iff (!arst_n)
        !wide && step_dn && count == ZERO32 && !inhibit && !init && !preset_in && !sw_preset
        |=> count == $past(lim16);
    endproperty
    a_dn16: assert property (p_dn16) else $error("16-bit underflow");
endmodule

// ===== core/hspc_decode.sv
`timescale 1ns/100ps
// Turns phase A/B samples into one count step per clock
module hspc_decode
    import hspc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Mode and inputs
    input wire logic [3:0] mode,
    input wire logic sw_down,
    input wire logic phase_a,
    input wire logic phase_b,
    // Step out
    output logic step_up,
    output logic step_dn
);
    logic a_q;
    logic b_q;
    hspc_family_t fam;

    // Previous samples for edge detection
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end
        else
        begin
            a_q <= phase_a;
            b_q <= phase_b;
        end
    end

    // Pairs of codes share a family; odd codes only change the width
    assign fam = hspc_family_t'(mode[3:1]);

    // Direction rules per family
    always_comb
    begin
        logic a_r;
        logic a_f;
        logic b_r;
        logic b_f;
        a_r = phase_a & ~a_q;
        a_f = ~phase_a & a_q;
        b_r = phase_b & ~b_q;
        b_f = ~phase_b & b_q;
        step_up = 1'b0;
        step_dn = 1'b0;
        case (fam)
            HSPC_EDGE1:
            begin
                step_up = b_r & phase_a;
                step_dn = b_f & phase_a;
            end
            HSPC_EDGE2:
            begin
                step_up = (b_r & phase_a) | (b_f & ~phase_a);
                step_dn = (b_f & phase_a) | (b_r & ~phase_a);
            end
            HSPC_EDGE4:
            begin
                step_up = (b_r & phase_a) | (b_f & ~phase_a) | (a_r & ~phase_b) | (a_f & phase_b);
                step_dn = (b_f & phase_a) | (b_r & ~phase_a) | (a_f & ~phase_b) | (a_r & phase_b);
            end
            HSPC_UPDN:
            begin
                // Simultaneous edges cancel
                step_up = a_r & ~b_r;
                step_dn = b_r & ~a_r;
            end
            HSPC_HWDIR:
            begin
                step_up = b_r & ~phase_a;
                step_dn = b_r & phase_a;
            end
            HSPC_SWDIR:
            begin
                step_up = b_r & ~sw_down;
                step_dn = b_r & sw_down;
            end
            default:
            begin
                step_up = 1'b0;
                step_dn = 1'b0;
            end
        endcase
    end
endmodule

// ===== core/hspc_top.sv
`timescale 1ns/100ps
module hspc_top
    import hspc_pkg::*;
#(
    parameter int NCH = 2
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Counter pins per channel
    input wire logic [NCH-1:0] phase_a,
    input wire logic [NCH-1:0] phase_b,
    input wire logic [NCH-1:0] preset_in,
    input wire logic [NCH-1:0] inhibit,
    // Compare outputs
    output logic [NCH-1:0] first_compare_output,
    output logic [NCH-1:0] second_compare_output
);
    logic rd_done;
    logic [31:0] rdata [NCH];
    logic [31:0] wmask;
    logic [7:0] offs;
    logic ch_sel;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign offs = avs_address & ~CH_STRIDE;
    assign ch_sel = avs_address[CH_SEL_BIT];

    // Byte lanes to bit mask
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end

    // Writes finish at once; reads wait one cycle for registered data
    assign avs_waitrequest = avs_read & ~rd_done;

    // Read done flag drops after each accepted read
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_done <= 1'b0;
        else
            rd_done <= avs_read & ~rd_done;
    end

    // Read data register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            avs_readdata <= ZERO32;
        else if (avs_read && !rd_done)
            avs_readdata <= rdata[ch_sel];
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic [3:0] mode;
            logic sw_down;
            logic [31:0] ring;
            logic [31:0] preset_val;
            logic [31:0] cmp1;
            logic [31:0] cmp2;
            logic [31:0] count;
            logic wr;
            logic init;
            logic clr1;
            logic clr2;
            logic sw_pre;
            logic step_up;
            logic step_dn;

            assign wr = avs_write && (ch_sel == 1'(g));
            // Writing the mode resets the channel's other settings
            assign init = wr && offs == REG_MODE && avs_byteenable[0]
                && avs_writedata[3:0] <= MODE_MAX;
            // Command bits act as one-cycle pulses
            assign clr1 = wr && offs == REG_CMD && avs_writedata[CMD_RST1_BIT];
            assign clr2 = wr && offs == REG_CMD && avs_writedata[CMD_RST2_BIT];
            assign sw_pre = wr && offs == REG_CMD && avs_writedata[CMD_PRESET_BIT];

            // Mode register; out-of-range codes are ignored
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    mode <= '0;
                else if (init)
                    mode <= avs_writedata[3:0];
            end

            // Settings registers, reset to defaults on mode write
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    sw_down <= 1'b0;
                    ring <= RING_RESET;
                    preset_val <= ZERO32;
                    cmp1 <= CMP_RESET;
                    cmp2 <= CMP_RESET;
                end
                else if (init)
                begin
                    sw_down <= 1'b0;
                    ring <= RING_RESET;
                    preset_val <= ZERO32;
                    cmp1 <= CMP_RESET;
                    cmp2 <= CMP_RESET;
                end
                else if (wr)
                begin
                    case (offs)
                        REG_DIR:
                            if (avs_byteenable[0])
                                sw_down <= avs_writedata[0];
                        REG_RING:
                            ring <= (ring & ~wmask) | (avs_writedata & wmask);
                        REG_PRESET:
                            preset_val <= (preset_val & ~wmask) | (avs_writedata & wmask);
                        REG_CMP1:
                            cmp1 <= (cmp1 & ~wmask) | (avs_writedata & wmask);
                        REG_CMP2:
                            cmp2 <= (cmp2 & ~wmask) | (avs_writedata & wmask);
                        default:
                            ;
                    endcase
                end
            end

            hspc_decode u_dec
            (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .mode(mode),
                .sw_down(sw_down),
                .phase_a(phase_a[g]),
                .phase_b(phase_b[g]),
                .step_up(step_up),
                .step_dn(step_dn)
            );

            hspc_channel u_ch
            (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .mode(mode),
                .ring(ring),
                .preset_val(preset_val),
                .cmp1(cmp1),
                .cmp2(cmp2),
                .init(init),
                .clr1(clr1),
                .clr2(clr2),
                .sw_preset(sw_pre),
                .step_up(step_up),
                .step_dn(step_dn),
                .preset_in(preset_in[g]),
                .inhibit(inhibit[g]),
                .count(count),
                .first_compare_output(first_compare_output[g]),
                .second_compare_output(second_compare_output[g])
            );

            // Read mux; status shows live outputs and pins
            always_comb
            begin
                case (offs)
                    REG_MODE: rdata[g] = {28'h000_0000, mode};
                    REG_DIR: rdata[g] = {31'h0000_0000, sw_down};
                    REG_RING: rdata[g] = ring;
                    REG_CMD: rdata[g] = ZERO32;
                    REG_PRESET: rdata[g] = preset_val;
                    REG_CMP1: rdata[g] = cmp1;
                    REG_CMP2: rdata[g] = cmp2;
                    REG_COUNT: rdata[g] = count;
                    REG_STATUS: rdata[g] = {26'h000_0000, inhibit[g], preset_in[g], phase_b[g], phase_a[g],
                        second_compare_output[g], first_compare_output[g]};
                    default: rdata[g] = UNMAPPED;
                endcase
            end

            // Software direction follows the direction register
            property p_swdir;
                @(posedge ref_clk) disable iff (!arst_n)
                mode[3:1] == 3'(HSPC_SWDIR) && step_up |-> !sw_down;
            endproperty
            a_swdir: assert property (p_swdir) else $error("wrong soft direction");
            property p_hwdir;
                @(posedge ref_clk) disable iff (!arst_n)
                mode[3:1] == 3'(HSPC_HWDIR) && step_dn |-> phase_a[g];
            endproperty
            a_hwdir: assert property (p_hwdir) else $error("wrong hard direction");
        end
    endgenerate

    // Read is answered exactly one cycle after it is raised
    sequence s_rd_wait;
        avs_read && avs_waitrequest;
    endsequence
    property p_rd_ans;
        @(posedge ref_clk) disable iff (!arst_n)
        s_rd_wait |=> !avs_waitrequest;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
endmodule

// ===== shared/hspc_pkg.sv
package hspc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one word per register)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_DIR = 8'h04;
    localparam logic [7:0] REG_RING = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_PRESET = 8'h10;
    localparam logic [7:0] REG_CMP1 = 8'h14;
    localparam logic [7:0] REG_CMP2 = 8'h18;
    localparam logic [7:0] REG_COUNT = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] CH_STRIDE = 8'h40;
    localparam int CH_SEL_BIT = 6;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CMD_RST1_BIT = 0;
    localparam int CMD_RST2_BIT = 1;
    localparam int CMD_PRESET_BIT = 2;
    localparam logic [3:0] MODE_MAX = 4'hB;
    localparam logic [31:0] RING_RESET = 32'h0001_0000;
    localparam logic [31:0] CMP_RESET = 32'h0000_7FFF;
    localparam logic [31:0] MAX16 = 32'h0000_FFFF;
    localparam logic [31:0] MAX32 = 32'h7FFF_FFFF;
    localparam logic [31:0] MIN32 = 32'h8000_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [31:0] ONE32 = 32'h0000_0001;
    localparam logic [31:0] UNMAPPED = 32'hDEAD_0000;

    // ------------------------------------------------------------
    // Timing: compare set within 30 ms, clear within 100 ms
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int SET_MAX_MS = 30;
    localparam int CLR_MAX_MS = 100;
    localparam int SET_MAX_CYC = SET_MAX_MS * 1000 * CLK_MHZ;
    localparam int CLR_MAX_CYC = CLR_MAX_MS * 1000 * CLK_MHZ;

    // Counting mode families, index = mode code / 2
    typedef enum logic [2:0]
    {
        HSPC_EDGE1,
        HSPC_EDGE2,
        HSPC_EDGE4,
        HSPC_UPDN,
        HSPC_HWDIR,
        HSPC_SWDIR
    } hspc_family_t;
endpackage

// ===== test/hspc_pulse_src.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Pulse source standing in for an encoder on each channel
// ------------------------------------------------------------
module hspc_pulse_src
    import hspc_pkg::*;
#(
    parameter int NCH = 2
)
(
    // Clock
    input wire logic ref_clk,
    // Encoder pins
    output logic [NCH-1:0] phase_a,
    output logic [NCH-1:0] phase_b
);
    // Pins start low so no edge shows at reset release
    initial
    begin
        phase_a = '0;
        phase_b = '0;
    end

    // Set both levels at once; gap lets the counter settle
    task automatic set_lv(input int ch, input logic a, input logic b, input int gap);
        @(posedge ref_clk);
        phase_a[ch] <= a;
        phase_b[ch] <= b;
        repeat (gap) @(posedge ref_clk);
    endtask

    // One transition on A (pin 0) or B (pin 1); a short gap answers promptly
    task automatic flip(input int ch, input logic pin, input int gap);
        @(posedge ref_clk);
        if (pin)
            phase_b[ch] <= ~phase_b[ch];
        else
            phase_a[ch] <= ~phase_a[ch];
        repeat (gap) @(posedge ref_clk);
    endtask
endmodule

// ===== test/hspc_tb_top.sv
`timescale 1ns/100ps
module hspc_tb_top
    import hspc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct {logic [3:0] mode; logic dir; logic a0; logic b0; logic pin; logic [31:0] exp;} hspc_row_t;
    logic ref_clk;
    logic arst_n;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] phase_a;
    logic [1:0] phase_b;
    logic [1:0] preset_in;
    logic [1:0] inhibit;
    logic [1:0] first_compare_output;
    logic [1:0] second_compare_output;
    logic wait_s;
    logic [31:0] rd_s;
    int fail_count;
    int checked;
    // Rows: mode, dir word, start A, start B, pin to flip, count after one flip
    hspc_row_t rows [14] = '{
        '{4'h0, 1'h0, 1'h1, 1'h0, 1'h1, ONE32}, '{4'h1, 1'h0, 1'h1, 1'h1, 1'h1, MAX16},
        '{4'h2, 1'h0, 1'h1, 1'h0, 1'h1, ONE32}, '{4'h3, 1'h0, 1'h1, 1'h0, 1'h1, ONE32},
        '{4'h4, 1'h0, 1'h1, 1'h0, 1'h1, ONE32}, '{4'h5, 1'h0, 1'h1, 1'h0, 1'h1, ONE32},
        '{4'h6, 1'h0, 1'h0, 1'h0, 1'h0, ONE32}, '{4'h7, 1'h0, 1'h0, 1'h0, 1'h1, MAX16},
        '{4'h8, 1'h0, 1'h1, 1'h0, 1'h1, 32'hFFFF_FFFF}, '{4'h9, 1'h0, 1'h0, 1'h0, 1'h1, ONE32},
        '{4'hA, 1'h1, 1'h0, 1'h0, 1'h1, 32'hFFFF_FFFF}, '{4'hB, 1'h0, 1'h1, 1'h0, 1'h1, ONE32},
        '{4'h8, 1'h0, 1'h0, 1'h0, 1'h1, ONE32}, '{4'hB, 1'h1, 1'h0, 1'h0, 1'h1, MAX16}};

    // ------------------------------------------------------------
    // Clock, design and pulse source
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    hspc_top #(.NCH(2)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .phase_a(phase_a), .phase_b(phase_b), .preset_in(preset_in), .inhibit(inhibit),
        .first_compare_output(first_compare_output), .second_compare_output(second_compare_output));

    hspc_pulse_src #(.NCH(2)) u_src (.ref_clk(ref_clk), .phase_a(phase_a), .phase_b(phase_b));

    // Bus answer is captured mid-cycle, where it is settled before the next edge
    always @(negedge ref_clk)
    begin
        wait_s = avs_waitrequest;
        rd_s = avs_readdata;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [7:0] ad(input int ch, input logic [7:0] off);
        return ch ? off + CH_STRIDE : off;
    endfunction

    // Hold the request until an edge sees waitrequest low; the watchdog ends a hang
    task automatic take();
        do
            @(posedge ref_clk);
        while (wait_s !== 1'h0);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'h1;
        take();
        avs_write <= 1'h0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= 1'h1;
        take();
        avs_read <= 1'h0;
        check(nm, rd_s, e);
    endtask

    task automatic outs(input logic [31:0] e);
        repeat (4) @(posedge ref_clk);
        check("outputs", {28'h000_0000, first_compare_output, second_compare_output}, e);
    endtask

    task automatic pin_set(input logic [1:0] p, input logic [1:0] i);
        @(posedge ref_clk);
        preset_in <= p;
        inhibit <= i;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog: the whole run needs under 600 cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int ch;
        arst_n = 1'h0;
        avs_address = 8'h00;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        preset_in = 2'h0;
        inhibit = 2'h0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'h1;
        outs(ZERO32);
        rchk("ring", REG_RING, RING_RESET);
        rchk("cmp1", REG_CMP1, CMP_RESET);
        rchk("cmp2", REG_CMP2, CMP_RESET);
        rchk("count", REG_COUNT, ZERO32);
        rchk("unmapped", 8'h24, UNMAPPED);
        bus_wr(REG_MODE, 32'h0000_000C);
        rchk("mode", REG_MODE, ZERO32);
        // Every mode code, alternating channels
        for (int i = 0; i < 14; i++)
        begin
            ch = i % 2;
            u_src.set_lv(ch, rows[i].a0, rows[i].b0, 4);
            bus_wr(ad(ch, REG_MODE), {28'h000_0000, rows[i].mode});
            bus_wr(ad(ch, REG_DIR), {31'h0000_0000, rows[i].dir});
            rchk("mode", ad(ch, REG_MODE), {28'h000_0000, rows[i].mode});
            u_src.flip(ch, rows[i].pin, 8);
            rchk("row count", ad(ch, REG_COUNT), rows[i].exp);
        end
        // Signed wrap through preset
        u_src.set_lv(0, 1'h0, 1'h0, 4);
        bus_wr(REG_MODE, 32'h0000_0006);
        bus_wr(REG_PRESET, MAX32);
        pin_set(2'h1, 2'h0);
        pin_set(2'h0, 2'h0);
        rchk("preset", REG_COUNT, MAX32);
        u_src.flip(0, 1'h0, 8);
        rchk("wrap up", REG_COUNT, MIN32);
        u_src.flip(0, 1'h0, 4);
        u_src.flip(0, 1'h1, 8);
        rchk("wrap down", REG_COUNT, MAX32);
        // Ring length 10 gives limit 9
        bus_wr(REG_MODE, 32'h0000_0007);
        bus_wr(REG_RING, 32'h0000_000A);
        bus_wr(REG_PRESET, 32'h0000_0009);
        pin_set(2'h1, 2'h0);
        pin_set(2'h0, 2'h0);
        rchk("preset16", REG_COUNT, 32'h0000_0009);
        u_src.flip(0, 1'h0, 8);
        rchk("ring up", REG_COUNT, ZERO32);
        u_src.flip(0, 1'h1, 4);
        u_src.flip(0, 1'h1, 8);
        rchk("ring down", REG_COUNT, 32'h0000_0009);
        pin_set(2'h0, 2'h1);
        u_src.flip(0, 1'h0, 2);
        u_src.flip(0, 1'h0, 8);
        rchk("inhibit", REG_COUNT, 32'h0000_0009);
        pin_set(2'h0, 2'h0);
        u_src.flip(0, 1'h0, 2);
        u_src.flip(0, 1'h0, 8);
        rchk("released", REG_COUNT, ZERO32);
        // Two compares on channel 0, channel 1 stays quiet
        u_src.set_lv(0, 1'h0, 1'h0, 4);
        bus_wr(REG_MODE, 32'h0000_0006);
        bus_wr(REG_CMP1, 32'h0000_0002);
        bus_wr(REG_CMP2, 32'h0000_0003);
        for (int k = 0; k < 4; k++)
            u_src.flip(0, 1'h0, 3);
        outs(32'h0000_0004);
        u_src.flip(0, 1'h0, 3);
        u_src.flip(0, 1'h0, 3);
        outs(32'h0000_0005);
        bus_wr(REG_CMD, 32'h0000_0001);
        outs(32'h0000_0001);
        u_src.flip(0, 1'h0, 3);
        u_src.flip(0, 1'h0, 3);
        outs(32'h0000_0001);
        bus_wr(REG_CMD, 32'h0000_0002);
        outs(ZERO32);
        wrap_up();
    end
endmodule
